// >>> common/cas_defs.svh
`ifndef CAS_DEFS_SVH
`define CAS_DEFS_SVH
// Behaviour
// - Mono sample data travels in the left-channel part of the frame unless a phase bit moves it right.
// - Clock-direction bit high makes the port master of bit clock and frame sync.
// - In master mode the sample rate comes from the internal master clock and its prescalers.
// - ADC output idles pulled low; mask bits give Hi-Z, pulls or driven levels.
// - Format bits, slot enable and PCM variant bit select one of six formats.
// - Every format sends each word most significant bit first.
// - Right justified: high phase, LSB sampled on last rise before sync falls.
// - Left justified: high phase, MSB valid at first rise after the transition.
// - I2S: low phase, MSB captured at second rise after the transition.
// - PCM without slots: low phase (high for the variant), MSB captured at second rise after transition.
// - Phase bits move that direction's data right by one word length.
// - Slot mode start comes from a 10-bit slot field; slot zero starts at rise one.
// - Slot mode right phase start depends on word length and slot start.
// - Slot mode releases the line early or after the LSB as the tri bit says.
// - A-law or mu-law companding is chosen apart for DAC and ADC paths.
// - Companding maps 14-bit mu-law or 13-bit A-law linear to sign, exponent, mantissa.
// - Mu-law code has all eight bits inverted, A-law only its even bits.
// - Byte-word bit forces 8-bit transfers whatever the word length field says.

`define CAS_ADDR_AFC 7'h04
`define CAS_ADDR_CMP 7'h05
`define CAS_ADDR_CLK 7'h06
`define CAS_ADDR_SLL 7'h3b
`define CAS_ADDR_PSO 7'h3c

`define CAS_RST_AFC 9'h050
`define CAS_RST_CMP 9'h000
`define CAS_RST_CLK 9'h140
`define CAS_RST_SLL 9'h000
`define CAS_RST_PSO 9'h000

`define CAS_MASK_AFC 9'h1fb
`define CAS_MASK_CMP 9'h03f
`define CAS_MASK_CLK 9'h1fd
`define CAS_MASK_SLL 9'h1ff
`define CAS_MASK_PSO 9'h1ff

`define CAS_AFC_ADC_PH 0
`define CAS_AFC_DAC_PH 1
`define CAS_AFC_FMT_LO 3
`define CAS_AFC_WORD_LENGTH_SEL_LO 5
`define CAS_CMP_ADC_LO 1
`define CAS_CMP_DAC_LO 3
`define CAS_CMP_FORCE8 5
`define CAS_CLK_MASTER 0
`define CAS_CLK_BSEL_LO 2
`define CAS_CLK_MSEL_LO 5
`define CAS_PSO_SLOT9 0
`define CAS_PSO_PCM_VARIANT_SEL 1
`define CAS_PSO_PULL_DIR 3
`define CAS_PSO_MASK_EN 4
`define CAS_PSO_MASK_SEL 5
`define CAS_PSO_TRI 7
`define CAS_PSO_SLOT_EN 8

`define CAS_CM_MU 2'b10
`define CAS_CM_A 2'b11
`define CAS_ALAW_XOR 8'h55
`define CAS_MU_BIAS 14'h0021
`define CAS_MU_CLIP 14'h1fde
`define CAS_A_CLIP 13'h0fff
`define CAS_FRAME_HALF 11'h020
`endif

// >>> common/cas_pkg.sv
package cas_pkg;
    typedef enum logic [5:0] {
        CAS_FMT_RJ = 6'b00_0001,
        CAS_FMT_LJ = 6'b00_0010,
        CAS_FMT_I2S = 6'b00_0100,
        CAS_FMT_PCMA = 6'b00_1000,
        CAS_FMT_PCM_VARIANT_SEL = 6'b01_0000,
        CAS_FMT_SLOT = 6'b10_0000
    } cas_fmt_t;

    typedef enum logic [1:0] {
        CAS_TX_IDLE = 2'b01,
        CAS_TX_DRIVE = 2'b10
    } cas_tx_state_t;
endpackage

// >>> core/cas_buf2.sv
`timescale 1ns/1ns
module cas_buf2 #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_q [2];
    logic wr_q;
    logic rd_q;
    logic [1:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                mem_q[wr_q] <= in_data;
                wr_q <= ~wr_q;
            end
            if (pop)
            begin
                rd_q <= ~rd_q;
            end
            cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        end
    end

    full_stall_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cnt_q == 2'h2 && !pop) |=> !in_ready) else $error("full buffer took a word");
endmodule

// >>> core/cas_port.sv
`timescale 1ns/1ns
`include "cas_defs.svh"
module cas_port #(
    parameter logic [10:0] FRAME_HALF = `CAS_FRAME_HALF
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [6:0] reg_addr,
    input wire logic [8:0] reg_wdata,
    output logic [8:0] reg_rdata,
    input wire logic bclk_i,
    output logic bclk_o,
    output logic bclk_oe,
    input wire logic frame_sync_i,
    output logic frame_sync_o,
    output logic frame_sync_oe,
    input wire logic dac_serial_in,
    output logic adc_serial_out,
    output logic adc_serial_out_oe,
    output logic adc_pull_up,
    output logic adc_pull_down,
    input wire logic [31:0] adc_sample,
    input wire logic adc_valid,
    output logic adc_ready,
    output logic [31:0] dac_sample,
    output logic dac_valid,
    input wire logic dac_ready
);
    // ------------------------------------------------------------
    // Companding functions.
    // ------------------------------------------------------------
    function automatic logic [7:0] mu_enc(input logic [13:0] s);
        logic [13:0] m;
        logic [2:0] e;
        m = s[13] ? 14'(14'h0000 - s) : s;
        if (m > `CAS_MU_CLIP) m = `CAS_MU_CLIP;
        m = 14'(m + `CAS_MU_BIAS);
        e = 3'h0;
        for (int i = 0; i < 8; i++) if (m[i+5]) e = 3'(i);
        return ~{s[13], e, 4'(m >> (4'(e) + 4'h1))};
    endfunction

    function automatic logic [31:0] mu_dec(input logic [7:0] code);
        logic [7:0] c;
        logic [14:0] t;
        c = ~code;
        t = 15'({c[3:0], 1'b0}) + 15'(`CAS_MU_BIAS);
        t = 15'(t << c[6:4]);
        t = 15'(t - 15'(`CAS_MU_BIAS));
        t = c[7] ? 15'(15'h0000 - t) : t;
        return {t[13:0], 18'h0_0000};
    endfunction

    function automatic logic [7:0] a_enc(input logic [12:0] s);
        logic [12:0] m;
        logic [2:0] e;
        m = s[12] ? 13'(13'h0000 - s) : s;
        if (m > `CAS_A_CLIP) m = `CAS_A_CLIP;
        e = 3'h0;
        for (int i = 5; i < 12; i++) if (m[i]) e = 3'(i - 4);
        return {~s[12], e, (e == 3'h0) ? m[4:1] : 4'(m >> e)} ^ `CAS_ALAW_XOR;
    endfunction

    function automatic logic [31:0] a_dec(input logic [7:0] code);
        logic [7:0] c;
        logic [12:0] t;
        c = code ^ `CAS_ALAW_XOR;
        t = 13'({c[3:0], 1'b0});
        if (c[6:4] == 3'h0) t = 13'(t + 13'h0001);
        else t = 13'(13'(t + 13'h0021) << (c[6:4] - 3'h1));
        t = c[7] ? t : 13'(13'h0000 - t);
        return {t, 19'h0_0000};
    endfunction

    // ------------------------------------------------------------
    // Control registers.
    // ------------------------------------------------------------
    logic [8:0] afc_q, cmp_q, clk_q, sll_q, pso_q;
    wire wr_afc = reg_wr_en && reg_addr == `CAS_ADDR_AFC;
    wire wr_cmp = reg_wr_en && reg_addr == `CAS_ADDR_CMP;
    wire wr_clk = reg_wr_en && reg_addr == `CAS_ADDR_CLK;
    wire wr_sll = reg_wr_en && reg_addr == `CAS_ADDR_SLL;
    wire wr_pso = reg_wr_en && reg_addr == `CAS_ADDR_PSO;
    wire [8:0] rd_mux = (reg_addr == `CAS_ADDR_AFC) ? afc_q :
                        (reg_addr == `CAS_ADDR_CMP) ? cmp_q :
                        (reg_addr == `CAS_ADDR_CLK) ? clk_q :
                        (reg_addr == `CAS_ADDR_SLL) ? sll_q :
                        (reg_addr == `CAS_ADDR_PSO) ? pso_q : 9'h000;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            afc_q <= `CAS_RST_AFC;
            cmp_q <= `CAS_RST_CMP;
            clk_q <= `CAS_RST_CLK;
            sll_q <= `CAS_RST_SLL;
            pso_q <= `CAS_RST_PSO;
            reg_rdata <= 9'h000;
        end
        else
        begin
            if (wr_afc) afc_q <= reg_wdata & `CAS_MASK_AFC;
            if (wr_cmp) cmp_q <= reg_wdata & `CAS_MASK_CMP;
            if (wr_clk) clk_q <= reg_wdata & `CAS_MASK_CLK;
            if (wr_sll) sll_q <= reg_wdata & `CAS_MASK_SLL;
            if (wr_pso) pso_q <= reg_wdata & `CAS_MASK_PSO;
            if (reg_rd_en) reg_rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Configuration decode.
    // ------------------------------------------------------------
    wire master = clk_q[`CAS_CLK_MASTER];
    wire [1:0] fmt_bits = afc_q[`CAS_AFC_FMT_LO +: 2];
    wire [1:0] word_length_sel = afc_q[`CAS_AFC_WORD_LENGTH_SEL_LO +: 2];
    wire [1:0] adc_cm = cmp_q[`CAS_CMP_ADC_LO +: 2];
    wire [1:0] dac_cm = cmp_q[`CAS_CMP_DAC_LO +: 2];
    wire force8 = cmp_q[`CAS_CMP_FORCE8];
    wire slot_en = pso_q[`CAS_PSO_SLOT_EN];
    wire tri_early = pso_q[`CAS_PSO_TRI];
    wire [10:0] slot = {1'b0, pso_q[`CAS_PSO_SLOT9], sll_q};
    cas_pkg::cas_fmt_t fmt;
    assign fmt = (fmt_bits != 2'b11) ? ((fmt_bits == 2'b00) ? cas_pkg::CAS_FMT_RJ :
                 (fmt_bits == 2'b01) ? cas_pkg::CAS_FMT_LJ : cas_pkg::CAS_FMT_I2S) :
                 slot_en ? cas_pkg::CAS_FMT_SLOT :
                 pso_q[`CAS_PSO_PCM_VARIANT_SEL] ? cas_pkg::CAS_FMT_PCM_VARIANT_SEL : cas_pkg::CAS_FMT_PCMA;
    wire [10:0] wl = force8 ? 11'h008 : (word_length_sel == 2'b00) ? 11'h010 :
                     (word_length_sel == 2'b01) ? 11'h014 : (word_length_sel == 2'b10) ? 11'h018 : 11'h020;
    wire start_high = fmt == cas_pkg::CAS_FMT_RJ || fmt == cas_pkg::CAS_FMT_LJ ||
                      fmt == cas_pkg::CAS_FMT_PCM_VARIANT_SEL;

    // ------------------------------------------------------------
    // Pin synchronisers and master clock generator.
    // ------------------------------------------------------------
    logic [2:0] sync1_q, sync2_q;
    logic bclk3_q;
    wire [2:0] pins = {dac_serial_in, frame_sync_i, bclk_i};
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_sync
            always_ff @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                end
                else
                begin
                    sync1_q[g] <= pins[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate

    logic [11:0] div_q;
    logic bclk_m_q, fs_m_q;
    logic [10:0] fs_cnt_q;
    wire [11:0] half = 12'(12'(clk_q[`CAS_CLK_MSEL_LO +: 3]) + 12'h001)
                       << clk_q[`CAS_CLK_BSEL_LO +: 3];
    wire tick = master && (div_q >= 12'(half - 12'h001));
    wire rise_m = tick && !bclk_m_q;
    wire fall_m = tick && bclk_m_q;
    wire fs_wrap = fs_cnt_q == 11'(FRAME_HALF - 11'h001);
    wire fs_m_d = (fall_m && fs_wrap) ? ~fs_m_q : fs_m_q;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_q <= 12'h000;
            bclk_m_q <= 1'b0;
            fs_m_q <= 1'b0;
            fs_cnt_q <= 11'h000;
            bclk3_q <= 1'b0;
        end
        else
        begin
            bclk3_q <= sync2_q[0];
            div_q <= tick ? 12'h000 : 12'(div_q + 12'h001);
            if (tick) bclk_m_q <= ~bclk_m_q;
            fs_m_q <= fs_m_d;
            if (fall_m) fs_cnt_q <= fs_wrap ? 11'h000 : 11'(fs_cnt_q + 11'h001);
        end
    end

    assign bclk_o = bclk_m_q;
    assign frame_sync_o = fs_m_q;
    assign bclk_oe = master;
    assign frame_sync_oe = master;
    wire rise_ev = master ? rise_m : (sync2_q[0] && !bclk3_q);
    wire fall_ev = master ? fall_m : (!sync2_q[0] && bclk3_q);
    wire fs_now = master ? fs_m_d : sync2_q[1];
    wire din = sync2_q[2];

    // ------------------------------------------------------------
    // Frame position and data window.
    // ------------------------------------------------------------
    logic fs_prev_q;
    logic [10:0] cnt_q, hi_len_q;
    wire new_frame = (fs_now != fs_prev_q) && (fs_now == start_high);
    wire [10:0] cnt_d = new_frame ? 11'h001 : 11'(cnt_q + 11'h001);
    wire [10:0] base = (fmt == cas_pkg::CAS_FMT_RJ) ? 11'(hi_len_q - wl + 11'h001) :
                       (fmt == cas_pkg::CAS_FMT_LJ) ? 11'h001 :
                       (fmt == cas_pkg::CAS_FMT_SLOT) ? 11'(slot + 11'h001) :
                       11'h002;
    wire [10:0] tx_start = 11'(base + (afc_q[`CAS_AFC_ADC_PH] ? wl : 11'h000));
    wire [10:0] rx_start = 11'(base + (afc_q[`CAS_AFC_DAC_PH] ? wl : 11'h000));
    wire [10:0] tx_last = 11'(tx_start + wl - 11'h001);
    wire [10:0] rx_last = 11'(rx_start + wl - 11'h001);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fs_prev_q <= 1'b0;
            cnt_q <= 11'h000;
            hi_len_q <= 11'h000;
        end
        else if (rise_ev)
        begin
            fs_prev_q <= fs_now;
            cnt_q <= cnt_d;
            if (fs_prev_q && !fs_now) hi_len_q <= cnt_q;
        end
    end

    // ------------------------------------------------------------
    // Transmit path toward the ADC output line.
    // ------------------------------------------------------------
    wire [7:0] adc_code = (adc_cm == `CAS_CM_A) ? a_enc(adc_sample[31:19]) :
                          mu_enc(adc_sample[31:18]);
    wire [31:0] adc_word = (adc_cm[1] ? {adc_code, 24'h00_0000} : adc_sample) &
                           ~(32'hffff_ffff >> wl);
    assign adc_ready = fall_ev && new_frame;
    cas_pkg::cas_tx_state_t tx_q;
    logic [31:0] tx_word_q;
    logic bit_q;
    wire [31:0] tx_sel = adc_ready ? (adc_valid ? adc_word : 32'h0000_0000) : tx_word_q;
    wire [10:0] tx_pos = adc_ready ? 11'h001 : 11'(cnt_q + 11'h001);
    wire tx_in_win = tx_pos >= tx_start && tx_pos <= tx_last;
    wire [4:0] tx_idx = 5'(11'h01f - 11'(tx_pos - tx_start));
    wire tri_rel = rise_ev && fmt == cas_pkg::CAS_FMT_SLOT && tri_early && cnt_d == tx_last;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_q <= cas_pkg::CAS_TX_IDLE;
            tx_word_q <= 32'h0000_0000;
            bit_q <= 1'b0;
        end
        else
        begin
            if (adc_ready) tx_word_q <= tx_sel;
            if (fall_ev && tx_in_win) bit_q <= tx_sel[tx_idx];
            case (tx_q)
                cas_pkg::CAS_TX_IDLE:
                begin
                    if (fall_ev && tx_in_win) tx_q <= cas_pkg::CAS_TX_DRIVE;
                end
                cas_pkg::CAS_TX_DRIVE:
                begin
                    if (tri_rel || (fall_ev && !tx_in_win)) tx_q <= cas_pkg::CAS_TX_IDLE;
                end
                default: tx_q <= cas_pkg::CAS_TX_IDLE;
            endcase
        end
    end

    wire drive = tx_q == cas_pkg::CAS_TX_DRIVE;
    wire m_sel = pso_q[`CAS_PSO_MASK_SEL];
    wire m_en = pso_q[`CAS_PSO_MASK_EN];
    wire p_dir = pso_q[`CAS_PSO_PULL_DIR];
    assign adc_serial_out = drive ? bit_q : (m_sel && m_en && p_dir);
    assign adc_serial_out_oe = drive || (m_sel && m_en);
    assign adc_pull_up = !drive && !m_sel && p_dir;
    assign adc_pull_down = !drive && !m_sel && !p_dir;

    // ------------------------------------------------------------
    // Receive path from the DAC input line.
    // ------------------------------------------------------------
    logic [31:0] rx_sh_q, pend_word_q;
    logic pend_q;
    logic buf_ready;
    wire rx_in_win = cnt_d >= rx_start && cnt_d <= rx_last;
    wire [31:0] rx_full = 32'({rx_sh_q[30:0], din} << 6'(11'h020 - wl));
    wire [31:0] rx_word = (dac_cm == `CAS_CM_A) ? a_dec(rx_full[31:24]) :
                          (dac_cm == `CAS_CM_MU) ? mu_dec(rx_full[31:24]) : rx_full;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_sh_q <= 32'h0000_0000;
            pend_word_q <= 32'h0000_0000;
            pend_q <= 1'b0;
        end
        else
        begin
            if (rise_ev && rx_in_win) rx_sh_q <= {rx_sh_q[30:0], din};
            if (rise_ev && cnt_d == rx_last)
            begin
                pend_q <= 1'b1;
                pend_word_q <= rx_word;
            end
            else if (buf_ready) pend_q <= 1'b0;
        end
    end

    cas_buf2 #(.W(32)) u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(pend_q),
        .in_ready(buf_ready),
        .in_data(pend_word_q),
        .out_valid(dac_valid),
        .out_ready(dac_ready),
        .out_data(dac_sample)
    );

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    sequence lsb_sampled;
        rise_ev && drive && fmt == cas_pkg::CAS_FMT_SLOT && tri_early && cnt_d == tx_last;
    endsequence
    clk_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
        bclk_oe == master && frame_sync_oe == master) else $error("clock direction wrong");
    idle_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!drive && pso_q[5:3] == 3'b000) |-> adc_pull_down && !adc_serial_out_oe)
        else $error("idle line not pulled low");
    byte_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        force8 |-> wl == 11'h008) else $error("byte words not forced");
    lj_msb_a: assert property (@(posedge clk) disable iff (sys_rst)
        (fall_ev && adc_ready && fmt == cas_pkg::CAS_FMT_LJ && !afc_q[0])
        |=> drive && bit_q == $past(tx_sel[31])) else $error("left justified msb late");
    i2s_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
        (fall_ev && adc_ready && fmt == cas_pkg::CAS_FMT_I2S && tx_q == cas_pkg::CAS_TX_IDLE)
        |=> !drive) else $error("i2s drove first bit slot");
    tri_early_a: assert property (@(posedge clk) disable iff (sys_rst)
        lsb_sampled |=> !drive) else $error("early release missed");
    mu_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        (adc_ready && adc_valid && adc_cm == `CAS_CM_MU && adc_sample == 32'h0000_0000)
        |=> tx_word_q[31:24] == 8'hff) else $error("mu-law inversion wrong");
    a_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        (adc_ready && adc_valid && adc_cm == `CAS_CM_A && adc_sample == 32'h0000_0000)
        |=> tx_word_q[31:24] == 8'hd5) else $error("a-law inversion wrong");
    rx_push_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pend_q && buf_ready && !(rise_ev && cnt_d == rx_last)) |=> !pend_q)
        else $error("received word stuck");
endmodule

// >>> dv/cas_host.sv
`timescale 1ns/1ns
module cas_host (
    input wire logic clk,
    input wire logic gen,
    input wire logic bclk_w,
    input wire logic fs_w,
    input wire logic adc_w,
    input wire logic [5:0] wl,
    input wire logic [31:0] tx_word,
    output logic bclk_h,
    output logic fs_h,
    output logic dac_h,
    output logic [31:0] rx_word,
    output logic rx_done
);
    logic [2:0] div_q = 3'h0;
    logic [3:0] per_q = 4'h0;
    logic bp_q = 1'b0;
    logic fp_q = 1'b0;
    logic [5:0] bits_q = 6'h3f;
    initial bclk_h = 1'b0;
    initial fs_h = 1'b0;
    initial dac_h = 1'b0;
    initial rx_word = 32'h0000_0000;
    initial rx_done = 1'b0;
    // ------------------------------------------------------------------
    // Slave clocks, still while gen is low; frame sync moves on a fall.
    // ------------------------------------------------------------------
    always @(posedge clk)
        if (gen && div_q == 3'h7)
        begin
            bclk_h <= ~bclk_h;
            per_q <= bclk_h ? per_q + 4'h1 : per_q;
            fs_h <= (bclk_h && per_q == 4'hf) ? ~fs_h : fs_h;
        end
    always @(posedge clk)
        div_q <= gen ? div_q + 3'h1 : div_q;
    // ------------------------------------------------------------------
    // Left justified data both ways; the data line toggles when spent.
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        bp_q <= bclk_w;
        rx_done <= 1'b0;
        if (bp_q && !bclk_w)
        begin
            fp_q <= fs_w;
            if (fs_w && !fp_q)
            begin
                bits_q <= 6'h0;
                dac_h <= tx_word[31];
            end
            else
                dac_h <= (bits_q < wl) ? tx_word[31 - bits_q] : ~dac_h;
        end
        if (!bp_q && bclk_w && bits_q < wl)
        begin
            rx_word <= {rx_word[30:0], adc_w};
            bits_q <= bits_q + 6'h1;
            rx_done <= (bits_q + 6'h1 == wl);
        end
    end
endmodule

// >>> dv/codec_audio_serial_port_tb.sv
`timescale 1ns/1ns
module codec_audio_serial_port_tb;
    logic clk = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, gen = 1'b0;
    logic dac_ready = 1'b1, adc_valid = 1'b1;
    logic [6:0] addr = 7'h00;
    logic [8:0] wdata = 9'h000;
    logic [31:0] adc_sample = 32'h0000_0000, tx_word = 32'h0000_0000;
    logic [31:0] last_dac = 32'h0000_0000;
    logic [5:0] wl = 6'h10;
    logic [8:0] reg_rdata;
    logic bclk_o, bclk_oe, fs_o, fs_oe, adc_o, adc_oe, pu, pd, adc_ready, dac_valid;
    logic bclk_h, fs_h, dac_h, rx_done;
    logic [31:0] dac_sample, rx_word;
    int errors = 0, checks = 0, pops = 0, p0;
    logic [6:0] ra [5] = '{7'h04, 7'h05, 7'h06, 7'h3b, 7'h3c};
    logic [8:0] rv [5] = '{9'h050, 9'h000, 9'h140, 9'h000, 9'h000};
    logic [8:0] rm [5] = '{9'h1fb, 9'h03f, 9'h1fd, 9'h1ff, 9'h1ff};
    logic [8:0] iv [5] = '{9'h000, 9'h020, 9'h038, 9'h030, 9'h008};
    logic [3:0] ie [5] = '{4'h1, 4'h0, 4'hc, 4'h8, 4'h2};
    wire bclk_w = bclk_oe ? bclk_o : bclk_h;
    wire fs_w = fs_oe ? fs_o : fs_h;
    wire adc_w = adc_oe ? adc_o : (pu ? 1'b1 : (pd ? 1'b0 : ~adc_o));
    always #10 clk = ~clk;
    always @(posedge clk)
        if (dac_valid === 1'b1 && dac_ready)
        begin
            last_dac <= dac_sample;
            pops <= pops + 1;
        end
    cas_port #(.FRAME_HALF(11'h010)) uut (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(wr_en),
        .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(reg_rdata),
        .bclk_i(bclk_w), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .frame_sync_i(fs_w),
        .frame_sync_o(fs_o), .frame_sync_oe(fs_oe), .dac_serial_in(dac_h),
        .adc_serial_out(adc_o), .adc_serial_out_oe(adc_oe), .adc_pull_up(pu),
        .adc_pull_down(pd), .adc_sample(adc_sample), .adc_valid(adc_valid),
        .adc_ready(adc_ready), .dac_sample(dac_sample), .dac_valid(dac_valid),
        .dac_ready(dac_ready));
    cas_host host (.clk(clk), .gen(gen), .bclk_w(bclk_w), .fs_w(fs_w), .adc_w(adc_w),
        .wl(wl), .tx_word(tx_word), .bclk_h(bclk_h), .fs_h(fs_h), .dac_h(dac_h),
        .rx_word(rx_word), .rx_done(rx_done));
    // ------------------------------------------------------------------
    // Access tasks and comparison.
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [8:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk("reg_rdata", {23'h0, e}, {23'h0, reg_rdata});
    endtask
    task automatic wait_rx;
        int n;
        n = 0;
        @(posedge clk);
        while (rx_done !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000)
            chk("rx_done", 32'h0000_0001, 32'h0000_0000);
    endtask
    // The first frame after a change may carry a stale word, so the second is judged.
    task automatic frame(input logic [31:0] ea, input logic [31:0] ed);
        wait_rx;
        wait_rx;
        repeat (8) @(posedge clk);
        chk("adc word", ea, rx_word & ((32'h1 << wl) - 32'h1));
        chk("dac word", ed, last_dac);
    endtask
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Test sequence.
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk("clock oe", 32'h0, {30'h0, bclk_oe, fs_oe});
        for (int i = 0; i < 5; i++)
            rd(ra[i], rv[i]);
        rd(7'h07, 9'h000);
        for (int i = 0; i < 5; i++)
        begin
            wr(ra[i], 9'h1ff);
            rd(ra[i], rm[i]);
        end
        wr(7'h06, 9'h140);
        wr(7'h05, 9'h000);
        wr(7'h04, 9'h008);
        for (int i = 0; i < 5; i++)
        begin
            wr(7'h3c, iv[i]);
            @(negedge clk);
            chk("adc idle", {28'h0, ie[i]}, {28'h0, adc_oe, adc_oe & adc_o, pu, pd});
        end
        wr(7'h3c, 9'h000);
        adc_sample <= 32'ha5c3_1234;
        tx_word <= 32'h9e37_0000;
        gen <= 1'b1;
        frame(32'h0000_a5c3, 32'h9e37_0000);
        wr(7'h05, 9'h020);
        wl <= 6'h08;
        frame(32'h0000_00a5, 32'h9e00_0000);
        wr(7'h05, 9'h034);
        adc_sample <= 32'h0000_0000;
        frame(32'h0000_00ff, 32'h227c_0000);
        wr(7'h05, 9'h03e);
        frame(32'h0000_00d5, 32'h0dc0_0000);
        wr(7'h05, 9'h000);
        wl <= 6'h10;
        dac_ready <= 1'b0;
        wait_rx;
        wait_rx;
        wait_rx;
        repeat (16) @(posedge clk);
        chk("dac_valid", 32'h1, {31'h0, dac_valid});
        p0 = pops;
        dac_ready <= 1'b1;
        repeat (4) @(posedge clk);
        // Two buffered words and the pending one drain on three edges.
        chk("dac pops", 32'h3, pops - p0);
        wr(7'h06, 9'h145);
        gen <= 1'b0;
        adc_sample <= 32'h5a3c_0000;
        @(negedge clk);
        chk("clock oe", 32'h3, {30'h0, bclk_oe, fs_oe});
        frame(32'h0000_5a3c, 32'h9e37_0000);
        wrap_up;
    end
    initial
    begin
        #1_000_000;
        errors++;
        $display("[FAIL] watchdog expected done seen timeout");
        wrap_up;
    end
endmodule
